// >>> pkg/pls_defines.svh
`ifndef PLS_DEFINES_SVH
`define PLS_DEFINES_SVH
// reference build depth and data width
`define PLS_DEPTH 32
`define PLS_DATA_W 32
// level counter reset value
`define PLS_LEVEL_RST 0
// pop control bit encodings
`define PLS_POP_KEEP 1'b0
`define PLS_POP_TAKE 1'b1
`endif

// >>> pkg/pls_pkg.sv
package pls_pkg;
  // one stack operand request from the pipeline
  typedef struct packed {
    logic sel;   // operand selects this stack
    logic pop;   // pop control bit
  } pls_opnd_t;
  // error pulses toward the local register set
  typedef struct packed {
    logic push_err;
    logic pop_err;
  } pls_err_t;
endpackage : pls_pkg

// >>> test/pls_pipe.sv
`timescale 1ns/1ps
// pipeline side: splits a command into three {sel, pop} operands
module pls_pipe
  import pls_pkg::*;
(
  input wire logic [5:0] cmd,
  output pls_opnd_t src_a,
  output pls_opnd_t src_b,
  output pls_opnd_t dst
);
  assign src_a = cmd[5:4]; // read pop bit
  assign src_b = cmd[3:2]; // same stack as src_a
  assign dst = cmd[1:0]; // write: push or pop and push
endmodule : pls_pipe

// >>> test/pls_props.sv
`timescale 1ns/1ps
// stack port checks
module pls_props
  import pls_pkg::*;
#(
  parameter int ADDR_W = 2
)
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire pls_opnd_t src_a,
  input wire pls_opnd_t src_b,
  input wire pls_opnd_t dst,
  input wire logic [31:0] wr_data,
  input wire logic [31:0] top_data,
  input wire logic full,
  input wire logic empty,
  input wire logic [ADDR_W:0] level,
  input wire pls_err_t err
);
  logic psh; // push request
  logic pp; // merged pop request
  assign psh = dst.sel;
  assign pp = src_a.sel & src_a.pop | src_b.sel & src_b.pop | dst.sel & dst.pop;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  flag_dec_a: assert property (full == level[ADDR_W] && empty == (level == 0)) else $error("flags");
  push_err_a: assert property (err.push_err == (psh && full && !pp)) else $error("push err");
  pop_err_a: assert property (err.pop_err == (pp && empty)) else $error("pop err");
  lvl_up_a: assert property (psh && !pp && !full |=> level == $past(level) + 1) else $error("up");
  lvl_pp_a: assert property (psh && pp && !empty |=> $stable(level)) else $error("pp");
  unf_hold_a: assert property (pp && !psh && empty |=> level == 0) else $error("unf");
  ovf_hold_a: assert property (psh && !pp && full |=> $stable(level)) else $error("ovf");
  top_new_a: assert property (psh && (pp || !full) |=> top_data == $past(wr_data)) else $error("top");
  cover property (psh && full);
  cover property (pp && empty);
  cover property (psh && pp && full);
endmodule : pls_props

// >>> test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import pls_pkg::*;
  logic core_clk = 0;
  logic rstn = 0;
  logic [5:0] cmd = 0;
  logic [31:0] wr_data = 0;
  logic [31:0] top_data;
  logic full;
  logic empty;
  logic [2:0] level;
  pls_opnd_t src_a, src_b, dst;
  pls_err_t err;
  int num_errors = 0;
  int tests_run = 0;
  pls_pipe pipe_u (.cmd, .src_a, .src_b, .dst);
  pls_stack #(.DEPTH(4)) dut_u (.core_clk, .rstn, .src_a, .src_b, .dst, .wr_data, .top_data, .full, .empty,
    .level, .err);
  initial forever #5 core_clk = ~core_clk;
  // compare and count
  task c(string n, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("Error %s exp %h got %h", n, e, g);
      num_errors++;
    end
  endtask : c
  // drive at falling edge, check error pulse, let the edge land
  task op(logic [5:0] k, logic [31:0] d, logic [1:0] e);
    @(negedge core_clk);
    cmd = k;
    wr_data = d;
    #1 c("err", e, err);
    @(posedge core_clk);
    #1;
  endtask : op
  task t_fill;
    for (int i = 1; i <= 4; i++)
    begin
      op(6'h02, 32'ha0 + i, 2'h0);
      c("top", 32'ha0 + i, top_data);
    end
    c("full", 1, full);
    op(6'h02, 32'hee, 2'h2);
    c("lvl", 4, level);
    c("top", 32'ha4, top_data);
  endtask : t_fill
  task t_drain;
    op(6'h03, 32'hb4, 2'h0);
    c("top", 32'hb4, top_data);
    op(6'h3c, 0, 2'h0);
    c("lvl", 3, level);
    repeat (3) op(6'h30, 0, 2'h0);
    c("empty", 1, empty); // stale top not compared
    op(6'h30, 0, 2'h1);
    c("lvl", 0, level);
  endtask : t_drain
  task t_pp_empty;
    op(6'h03, 32'hc1, 2'h1);
    c("lvl", 1, level);
    c("top", 32'hc1, top_data);
    op(6'h00, 0, 2'h0);
  endtask : t_pp_empty
  task test_done;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  initial
  begin
    repeat (10) @(negedge core_clk);
    rstn = 1;
    t_fill();
    t_drain();
    t_pp_empty();
    test_done();
  end
endmodule : tb_top
bind pls_stack pls_props #(.ADDR_W(ADDR_W)) chk_u (.core_clk, .rstn, .src_a, .src_b, .dst, .wr_data,
  .top_data, .full, .empty, .level, .err);

// >>> verilog/pls_level.sv
`timescale 1ns/1ps
`include "pls_defines.svh"
// level counter with full/empty decode and protections
module pls_level
  import pls_pkg::*;
#(
  parameter int ADDR_W = 5,
  parameter bit PROT_POP = 1'b1,
  parameter bit PROT_PUSH = 1'b1
)
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic push,
  input wire logic pop,
  output logic full,
  output logic empty,
  output logic [ADDR_W:0] level,
  output logic [ADDR_W-1:0] wr_addr,
  output logic wr_en,
  output pls_err_t err
);
  logic [ADDR_W:0] next_level; // next level value
  logic pop_eff; // pop that may move the pointer
  logic push_eff; // push that may move the pointer

  // full from msb, empty from all zero
  assign full = level[ADDR_W];
  assign empty = (level == '0);

  // next level and write decisions
  always_comb
  begin
    err.pop_err = pop & empty;
    err.push_err = push & full & ~pop;
    pop_eff = pop & ~(PROT_POP & empty);
    push_eff = push & ~(PROT_PUSH & err.push_err);
    next_level = level;
    if (pop_eff && push_eff)
    begin
      next_level = level;
    end
    else if (pop_eff)
    begin
      next_level = level - 1'b1;
    end
    else if (push_eff)
    begin
      next_level = level + 1'b1;
    end
    // pop&push on empty with protection acts as push
    if (pop && push_eff && empty && PROT_POP)
    begin
      next_level = level + 1'b1;
    end
    wr_en = push_eff;
    // write lands at low bits of the post-push level
    if (pop_eff)
    begin
      wr_addr = level[ADDR_W-1:0];
    end
    else
    begin
      wr_addr = next_level[ADDR_W-1:0];
    end
  end

  // level register, the only pointer
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      level <= (ADDR_W+1)'(`PLS_LEVEL_RST);
    end
    else
    begin
      level <= next_level;
    end
  end
endmodule : pls_level

// >>> verilog/pls_stack.sv
`timescale 1ns/1ps
`include "pls_defines.svh"
module pls_stack
  import pls_pkg::*;
#(
  parameter int DEPTH = `PLS_DEPTH, // power of two
  parameter int DATA_W = `PLS_DATA_W,
  parameter bit PROT_POP = 1'b1,
  parameter bit PROT_PUSH = 1'b1,
  parameter int ADDR_W = $clog2(DEPTH)
)
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire pls_opnd_t src_a, // first source operand
  input wire pls_opnd_t src_b, // second source operand
  input wire pls_opnd_t dst, // destination operand
  input wire logic [DATA_W-1:0] wr_data, // result to store
  output logic [DATA_W-1:0] top_data, // registered top entry
  output logic full,
  output logic empty,
  output logic [ADDR_W:0] level,
  output pls_err_t err // to local register set
);
  logic [DATA_W-1:0] mem [DEPTH]; // stack storage
  logic pop; // combined pop request
  logic push; // write request
  logic wr_en; // memory write strobe
  logic [ADDR_W-1:0] wr_addr; // memory write location
  logic [ADDR_W:0] next_level; // level after a pop, or the current level when wr_en writes
  logic [DATA_W-1:0] next_top; // next shown top value

  // decode operand sel and pop bits into push and pop
  always_comb
  begin
    push = dst.sel; // write: bit 1 push, bits 1 and 0 pop&push
    pop = (src_a.sel & src_a.pop) | (src_b.sel & src_b.pop)
      | (dst.sel & dst.pop); // single ORed pop
  end

  // pointer, decode and protection
  pls_level #(
    .ADDR_W(ADDR_W),
    .PROT_POP(PROT_POP),
    .PROT_PUSH(PROT_PUSH)
  ) u_level (
    .core_clk(core_clk),
    .rstn(rstn),
    .push(push),
    .pop(pop),
    .full(full),
    .empty(empty),
    .level(level),
    .wr_addr(wr_addr),
    .wr_en(wr_en),
    .err(err)
  );

  // top value after this cycle: written data wins, else stored top
  always_comb
  begin
    next_level = level;
    if (wr_en)
    begin
      next_top = wr_data;
    end
    else
    begin
      next_level = level - {{ADDR_W{1'b0}}, (pop & ~empty)};
      // after emptying this is stale location 0 data
      next_top = mem[next_level[ADDR_W-1:0]];
    end
  end

  // memory write and top register
  always_ff @(posedge core_clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    if (!rstn)
    begin
      top_data <= '0;
    end
    else
    begin
      top_data <= next_top;
    end
  end
endmodule : pls_stack
